// [rtl/byte_bit_execute_subset.sv]
// execute stage for add, and, bit and clear instructions of the core
`timescale 1ns/100ps
`default_nettype none
`include "exec_defines.svh"

module byte_bit_execute_subset (
  input  wire logic                sys_clk_i,
  input  wire logic                reset_i,
  input  wire logic                op_valid_i,
  input  wire exec_pkg::op_t       op_code_i,
  input  wire logic [`ADDR_W-1:0]  file_addr_i,
  input  wire logic                dest_sel_i,
  input  wire logic [`BIDX_W-1:0]  bit_idx_i,
  input  wire logic [`DATA_W-1:0]  literal_i,
  input  wire logic [`DATA_W-1:0]  mem_rd_data_i,
  output logic                     op_ready_o,
  output logic      [`ADDR_W-1:0]  mem_addr_o,
  output logic                     mem_wr_o,
  output logic      [`DATA_W-1:0]  mem_wr_data_o,
  output logic      [`DATA_W-1:0]  acc_o,
  output logic                     carry_o,
  output logic                     half_overflow_bit_o,
  output logic                     zero_o,
  output logic                     skip_o,
  output logic                     instr_done_o
);
  import exec_pkg::*;

  state_t                 state_r;
  op_t                    op_r;
  logic [`ADDR_W-1:0]     addr_r;
  logic                   dest_r;
  logic [`BIDX_W-1:0]     bidx_r;
  logic [`DATA_W-1:0]     lit_r;
  logic [`DATA_W-1:0]     file_r;
  logic [`DATA_W-1:0]     acc_r;
  logic                   carry_r;
  logic                   half_r;
  logic                   zero_r;
  logic                   mem_wr_r;
  logic [`DATA_W-1:0]     mem_wr_data_r;
  logic                   skip_pend_r;
  logic [`SKIP_CNT_W-1:0] skip_cnt_r;
  logic                   accept;
  logic                   skip_last;
  logic                   is_literal;
  logic                   is_sum;
  logic                   is_byte_file;
  logic                   wr_acc_nxt;
  logic                   wr_file_nxt;
  logic                   skip_nxt;
  logic [`DATA_W-1:0]     res_nxt;
  logic [`DATA_W-1:0]     alu_res;
  logic                   alu_carry;
  logic                   alu_half;
  logic                   alu_zero;
  logic [`DATA_W-1:0]     bit_set_val;
  logic [`DATA_W-1:0]     bit_clr_val;
  logic                   bit_val;

  // handshake and status outputs
  assign skip_last  = (skip_cnt_r == `SKIP_CNT_W'(`SKIP_LAST));
  assign op_ready_o = (state_r == st_idle)
                    | ((state_r == st_q4) & ~skip_pend_r);
  assign accept     = op_valid_i & op_ready_o;
  assign skip_o     = (state_r == st_skip);
  assign instr_done_o = ((state_r == st_q4) & ~skip_pend_r)
                      | ((state_r == st_skip) & skip_last);
  assign mem_addr_o    = addr_r;
  assign mem_wr_o      = mem_wr_r;
  assign mem_wr_data_o = mem_wr_data_r;
  assign acc_o         = acc_r;
  assign carry_o       = carry_r;
  assign half_overflow_bit_o = half_r;
  assign zero_o        = zero_r;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= st_idle;
    end else begin
      unique case (state_r)
        st_idle: if (accept) state_r <= st_q1;
        st_q1:   state_r <= st_q2;
        st_q2:   state_r <= st_q3;
        st_q3:   state_r <= st_q4;
        st_q4: begin
          if (skip_pend_r) state_r <= st_skip;
          else if (accept) state_r <= st_q1;
          else             state_r <= st_idle;
        end
        st_skip: if (skip_last) state_r <= st_idle;
      endcase
    end
  end

  // nop phase counter during a skipped instruction
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      skip_cnt_r <= '0;
    end else if (state_r == st_skip) begin
      skip_cnt_r <= skip_cnt_r + `SKIP_CNT_W'(1);
    end else begin
      skip_cnt_r <= '0;
    end
  end

  // operand capture when an instruction is taken
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      op_r   <= op_none;
      addr_r <= '0;
      dest_r <= `DEST_ACC;
      bidx_r <= '0;
      lit_r  <= `ZERO_BYTE;
    end else if (accept) begin
      op_r   <= op_code_i;
      addr_r <= file_addr_i;
      dest_r <= dest_sel_i;
      bidx_r <= bit_idx_i;
      lit_r  <= literal_i;
    end
  end

  // file register read in the first phase
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      file_r <= `ZERO_BYTE;
    end else if (state_r == st_q1) begin
      file_r <= mem_rd_data_i;
    end
  end

  // operation decode
  assign is_literal   = (op_r == sum_literal_op) | (op_r == mask_literal_op);
  assign is_sum       = (op_r == sum_literal_op) | (op_r == sum_file_op);
  assign is_byte_file = (op_r == sum_file_op) | (op_r == mask_file_op);

  byte_alu u_alu (
    .acc_i     (acc_r),
    .operand_i (is_literal ? lit_r : file_r),
    .use_sum_i (is_sum),
    .result_o  (alu_res),
    .carry_o   (alu_carry),
    .half_o    (alu_half),
    .zero_o    (alu_zero)
  );

  bit_unit u_bit (
    .data_i (file_r),
    .idx_i  (bidx_r),
    .set_o  (bit_set_val),
    .clr_o  (bit_clr_val),
    .bit_o  (bit_val)
  );

  // result select, destination and skip decision
  always_comb begin
    res_nxt     = alu_res;
    wr_acc_nxt  = 1'b0;
    wr_file_nxt = 1'b0;
    skip_nxt    = 1'b0;
    unique case (op_r)
      sum_literal_op, mask_literal_op: wr_acc_nxt = 1'b1;
      sum_file_op, mask_file_op: begin
        wr_acc_nxt  = (dest_r == `DEST_ACC);
        wr_file_nxt = (dest_r == `DEST_FILE);
      end
      bit_clear_op: begin
        res_nxt     = bit_clr_val;
        wr_file_nxt = 1'b1;
      end
      bit_set_op: begin
        res_nxt     = bit_set_val;
        wr_file_nxt = 1'b1;
      end
      skip_if_one_op: skip_nxt = bit_val;
      skip_if_zero_op: skip_nxt = ~bit_val;
      file_zero_op: begin
        res_nxt     = `ZERO_BYTE;
        wr_file_nxt = 1'b1;
      end
      op_none: res_nxt = alu_res;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      acc_r <= `ACC_RESET;
    end else if ((state_r == st_q2) && wr_acc_nxt) begin
      acc_r <= res_nxt;
    end
  end

  // file write strobe, high in third phase
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mem_wr_r      <= 1'b0;
      mem_wr_data_r <= `ZERO_BYTE;
    end else begin
      mem_wr_r <= (state_r == st_q2) && wr_file_nxt;
      if ((state_r == st_q2) && wr_file_nxt) mem_wr_data_r <= res_nxt;
    end
  end

  // status flags from the alu sum or mask result, zero forced high by file clear
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      carry_r <= `FLAG_RESET;
      half_r  <= `FLAG_RESET;
      zero_r  <= `FLAG_RESET;
    end else if (state_r == st_q2) begin
      if (is_sum) begin
        carry_r <= alu_carry;
        half_r  <= alu_half;
      end
      if (is_sum || is_byte_file || is_literal) zero_r <= alu_zero;
      else if (op_r == file_zero_op) zero_r <= 1'b1;
    end
  end

  // pending skip from the bit test
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      skip_pend_r <= 1'b0;
    end else if (state_r == st_q2) begin
      skip_pend_r <= skip_nxt;
    end else if (state_r == st_q4) begin
      skip_pend_r <= 1'b0;
    end
  end

  // checks on the datapath
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_sum_lit_acc: assert property (
    (state_r == st_q3 && op_r == sum_literal_op)
    |-> acc_r == `DATA_W'($past(acc_r) + $past(lit_r)))
    else $error("literal sum wrong");

  a_sum_file_wr: assert property (
    (state_r == st_q3 && op_r == sum_file_op && dest_r == `DEST_FILE)
    |-> mem_wr_o && mem_wr_data_o == `DATA_W'(acc_r + $past(file_r)))
    else $error("file sum wrong");

  a_dest_acc_nowr: assert property (
    (state_r == st_q3 && is_byte_file && dest_r == `DEST_ACC)
    |-> !mem_wr_o
        && acc_r == (is_sum ? `DATA_W'($past(acc_r) + $past(file_r))
                            : ($past(acc_r) & $past(file_r))))
    else $error("destination select wrong");

  a_mask_file_flags: assert property (
    (state_r == st_q3 && op_r == mask_file_op)
    |-> $stable(carry_r) && $stable(half_r)
        && zero_r == (($past(acc_r) & $past(file_r)) == `ZERO_BYTE))
    else $error("mask file flags wrong");

  a_mask_lit_acc: assert property (
    (state_r == st_q3 && op_r == mask_literal_op)
    |-> acc_r == ($past(acc_r) & $past(lit_r)) && $stable(carry_r))
    else $error("literal mask wrong");

  a_bit_clear_val: assert property (
    (state_r == st_q3 && op_r == bit_clear_op)
    |-> mem_wr_o && !mem_wr_data_o[bidx_r]
        && $stable({carry_r, half_r, zero_r}))
    else $error("bit clear wrong");

  a_bit_set_val: assert property (
    (state_r == st_q3 && op_r == bit_set_op)
    |-> mem_wr_o && mem_wr_data_o[bidx_r]
        && $stable({carry_r, half_r, zero_r}))
    else $error("bit set wrong");

  a_skip_one_nop: assert property (
    (state_r == st_q2 && op_r == skip_if_one_op && file_r[bidx_r])
    |-> ##2 !op_ready_o ##1 skip_o [*4] ##1 !skip_o)
    else $error("skip on one missing");

  a_skip_zero_nop: assert property (
    (state_r == st_q2 && op_r == skip_if_zero_op && !file_r[bidx_r])
    |-> ##2 !op_ready_o ##1 skip_o [*4] ##1 !skip_o)
    else $error("skip on zero missing");

  a_skip_flags_hold: assert property (
    skip_o |-> $stable({acc_r, carry_r, half_r, zero_r}) && !mem_wr_o)
    else $error("state changed during skip");

  a_file_zero_flag: assert property (
    (state_r == st_q3 && op_r == file_zero_op)
    |-> mem_wr_o && mem_wr_data_o == `ZERO_BYTE && zero_r)
    else $error("file clear wrong");

  a_instr_four_cyc: assert property (
    (state_r == st_q1 && op_r != skip_if_one_op && op_r != skip_if_zero_op)
    |-> !instr_done_o [*3] ##1 instr_done_o)
    else $error("instruction period wrong");

  a_sum_carry_flags: assert property (
    (state_r == st_q3 && op_r == sum_literal_op)
    |-> {carry_r, acc_r} == ({1'b0, $past(acc_r)} + {1'b0, $past(lit_r)})
        && half_r == 1'(({1'b0, $past(acc_r[3:0])}
                         + {1'b0, $past(lit_r[3:0])}) >> 4)
        && zero_r == (acc_r == `ZERO_BYTE))
    else $error("arithmetic flags wrong");

  c_sum_file: cover property (state_r == st_q3 && op_r == sum_file_op);
  c_skip_taken: cover property (skip_o && skip_last);
  c_back_to_back: cover property (instr_done_o && accept);
  c_carry_out: cover property (state_r == st_q3 && is_sum && carry_r);

endmodule
`default_nettype wire

// [rtl/exec_defines.svh]
// constants for the byte and bit execute datapath
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH

`define DATA_W           8
`define ADDR_W           7
`define BIDX_W           3
`define NIBBLE_CARRY     4
`define BYTE_CARRY       8
`define ZERO_BYTE        8'h00
`define ONE_BIT_MASK     8'h01
`define ACC_RESET        8'h00
`define FLAG_RESET       1'b0
`define DEST_ACC         1'b0
`define DEST_FILE        1'b1
`define CLK_PERIOD_NS    20
`define OSC_PER_INSTR    4
`define INSTR_PERIOD_NS  (`OSC_PER_INSTR * `CLK_PERIOD_NS)
`define INSTR_CYCLES     (`INSTR_PERIOD_NS / `CLK_PERIOD_NS)
`define SKIP_CNT_W       2
`define SKIP_LAST        (`INSTR_CYCLES - 1)

`endif

// [rtl/exec_pkg.sv]
// types shared by the execute datapath modules
`default_nettype none
package exec_pkg;

  typedef enum logic [3:0] {
    op_none,
    sum_literal_op,
    sum_file_op,
    mask_file_op,
    mask_literal_op,
    bit_clear_op,
    bit_set_op,
    skip_if_one_op,
    skip_if_zero_op,
    file_zero_op
  } op_t;

  typedef enum logic [2:0] {
    st_idle,
    st_q1,
    st_q2,
    st_q3,
    st_q4,
    st_skip
  } state_t;

endpackage
`default_nettype wire

// [rtl/byte_alu.sv]
// ripple adder and bitwise and with carry, half carry and zero flags
`timescale 1ns/100ps
`default_nettype none
`include "exec_defines.svh"

module byte_alu (
  input  wire logic [`DATA_W-1:0] acc_i,
  input  wire logic [`DATA_W-1:0] operand_i,
  input  wire logic               use_sum_i,
  output logic      [`DATA_W-1:0] result_o,
  output logic                    carry_o,
  output logic                    half_o,
  output logic                    zero_o
);

  logic [`DATA_W:0]   carry_chain;
  logic [`DATA_W-1:0] sum;

  assign carry_chain[0] = 1'b0;

  // one full adder per bit
  for (genvar i = 0; i < `DATA_W; i++) begin : g_fa
    assign sum[i] = acc_i[i] ^ operand_i[i] ^ carry_chain[i];
    assign carry_chain[i+1] = (acc_i[i] & operand_i[i])
                            | (carry_chain[i] & (acc_i[i] ^ operand_i[i]));
  end

  // select sum or mask and derive flags
  assign result_o = use_sum_i ? sum : (acc_i & operand_i);
  assign carry_o  = carry_chain[`BYTE_CARRY];
  assign half_o   = carry_chain[`NIBBLE_CARRY];
  assign zero_o   = (result_o == `ZERO_BYTE);

endmodule
`default_nettype wire

// [rtl/bit_unit.sv]
// single bit set, clear and test on a byte
`timescale 1ns/100ps
`default_nettype none
`include "exec_defines.svh"

module bit_unit (
  input  wire logic [`DATA_W-1:0] data_i,
  input  wire logic [`BIDX_W-1:0] idx_i,
  output logic      [`DATA_W-1:0] set_o,
  output logic      [`DATA_W-1:0] clr_o,
  output logic                    bit_o
);

  // one-hot mask for the selected bit
  function automatic logic [`DATA_W-1:0] bit_mask(
    input logic [`BIDX_W-1:0] idx
  );
    bit_mask = `ONE_BIT_MASK << idx;
  endfunction

  assign set_o = data_i | bit_mask(idx_i);
  assign clr_o = data_i & ~bit_mask(idx_i);
  assign bit_o = |(data_i & bit_mask(idx_i));

endmodule
`default_nettype wire

// [testbench/file_mem_model.sv]
// data memory model that answers the execute stage
`timescale 1ns/100ps
`default_nettype none
`include "exec_defines.svh"

module file_mem_model (
  input  wire logic               sys_clk_i,
  input  wire logic [`ADDR_W-1:0] mem_addr_i,
  input  wire logic               mem_wr_i,
  input  wire logic [`DATA_W-1:0] mem_wr_data_i,
  output logic      [`DATA_W-1:0] mem_rd_data_o
);
  logic [`DATA_W-1:0] mem [0:(1<<`ADDR_W)-1];

  // preload a pattern that differs per address
  initial begin
    for (int i = 0; i < (1 << `ADDR_W); i++) begin
      mem[i] = 8'(i * 37) ^ 8'h5a;
    end
  end

  // combinational read so data is ready in the first phase
  assign mem_rd_data_o = mem[mem_addr_i];

  // write lands on the edge that ends the write phase
  always @(posedge sys_clk_i) begin
    if (mem_wr_i) begin
      mem[mem_addr_i] <= mem_wr_data_i;
    end
  end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the byte and bit execute stage
`timescale 1ns/100ps
`default_nettype none
`include "exec_defines.svh"

module testbench;
  import exec_pkg::*;

  typedef struct {
    logic [7:0] acc;
    logic       c, ho, z, skp;
    logic [6:0] a;
    logic [7:0] m;
    int         len;
  } note_t;

  logic       clk = 0, rst = 1, valid = 0, dest = 0;
  op_t        op = op_none;
  logic [6:0] addr = 0, maddr;
  logic [2:0] idx = 0;
  logic [7:0] lit = 0, rd_data, mwdata, acc;
  logic       ready, mwr, carry, half, zero, skip, done;
  int         mismatches = 0, cmp_count = 0, seed = 32'h3cdb, cnt = 0;
  logic [31:0] rv;
  note_t      q[$];
  note_t      mt;
  logic [7:0] r_acc = 0, r_mem [0:127];
  logic       r_c = 0, r_ho = 0, r_z = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  byte_bit_execute_subset dut (
    .sys_clk_i(clk), .reset_i(rst), .op_valid_i(valid), .op_code_i(op),
    .file_addr_i(addr), .dest_sel_i(dest), .bit_idx_i(idx),
    .literal_i(lit), .mem_rd_data_i(rd_data), .op_ready_o(ready),
    .mem_addr_o(maddr), .mem_wr_o(mwr), .mem_wr_data_o(mwdata),
    .acc_o(acc), .carry_o(carry), .half_overflow_bit_o(half),
    .zero_o(zero), .skip_o(skip), .instr_done_o(done));

  file_mem_model mem_u (
    .sys_clk_i(clk), .mem_addr_i(maddr), .mem_wr_i(mwr),
    .mem_wr_data_i(mwdata), .mem_rd_data_o(rd_data));

  task cmp8(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask

  task cmp1(string n, logic e, logic g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s exp %b got %b", n, e, g);
    end
  endtask

  task summarize;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // offer one instruction, then note its expected outcome
  task issue(op_t o, logic [6:0] a, logic d, logic [2:0] b, logic [7:0] k);
    note_t      t;
    logic [8:0] s;
    logic [4:0] s4;
    logic [7:0] f, r, res;
    logic       to_file;
    int         n;
    op = o;
    addr = a;
    dest = d;
    idx = b;
    lit = k;
    valid = 1;
    n = 0;
    @(negedge clk);
    while (ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20) begin
      mismatches++;
      summarize;
    end
    @(posedge clk);
    #1;
    f = r_mem[a];
    r = (o == sum_literal_op || o == mask_literal_op) ? k : f;
    to_file = (o == sum_file_op || o == mask_file_op) && d;
    t.skp = 0;
    case (o)
      sum_literal_op, sum_file_op: begin
        s = {1'b0, r_acc} + {1'b0, r};
        s4 = {1'b0, r_acc[3:0]} + {1'b0, r[3:0]};
        res = s[7:0];
        r_c = s[8];
        r_ho = s4[4];
        r_z = (res == 8'h00);
      end
      mask_literal_op, mask_file_op: begin
        res = r_acc & r;
        r_z = (res == 8'h00);
      end
      bit_clear_op: r_mem[a][b] = 1'b0;
      bit_set_op:   r_mem[a][b] = 1'b1;
      skip_if_one_op:  t.skp = f[b];
      skip_if_zero_op: t.skp = !f[b];
      file_zero_op: begin
        r_mem[a] = 8'h00;
        r_z = 1'b1;
      end
      default: ;
    endcase
    if (o inside {sum_literal_op, sum_file_op, mask_literal_op,
                  mask_file_op}) begin
      if (to_file) begin
        r_mem[a] = res;
      end else begin
        r_acc = res;
      end
    end
    t.len = t.skp ? 8 : 4;
    t.acc = r_acc;
    t.c = r_c;
    t.ho = r_ho;
    t.z = r_z;
    t.a = a;
    t.m = r_mem[a];
    q.push_back(t);
  endtask

  // watch completions and measure cycles since the take
  always @(posedge clk) begin
    if (!rst) begin
      if (done === 1'b1) begin
        if (q.size() == 0) begin
          mismatches++;
          $display("unexpected done exp 0 got 1");
        end else begin
          mt = q.pop_front();
          cmp8("acc", mt.acc, acc);
          cmp1("carry", mt.c, carry);
          cmp1("half", mt.ho, half);
          cmp1("zero", mt.z, zero);
          cmp1("skip", mt.skp, skip);
          cmp8("mem", mt.m, mem_u.mem[mt.a]);
          cmp8("cycles", 8'(mt.len), 8'(cnt + 1));
        end
      end
      if (valid && ready === 1'b1) begin
        cnt = 0;
      end else begin
        cnt++;
      end
    end
  end

  // main sequence
  initial begin
    int n;
    for (int i = 0; i < 128; i++) begin
      r_mem[i] = 8'(i * 37) ^ 8'h5a;
    end
    repeat (12) @(posedge clk);
    #1;
    rst = 0;
    // carry and half carry ripple to a zero sum
    issue(sum_literal_op, 7'h00, 1'b0, 3'd0, 8'hff);
    issue(sum_literal_op, 7'h00, 1'b0, 3'd0, 8'h01);
    issue(mask_literal_op, 7'h00, 1'b0, 3'd0, 8'h00);
    issue(sum_literal_op, 7'h00, 1'b0, 3'd0, 8'h0f);
    issue(sum_literal_op, 7'h00, 1'b0, 3'd0, 8'h01);
    // every operation at both destinations on the boundary address
    for (int o = 0; o < 10; o++) begin
      issue(op_t'(4'(o)), 7'h7f, 1'b0, 3'd7, 8'ha5);
      issue(op_t'(4'(o)), 7'h7f, 1'b1, 3'd7, 8'h5a);
    end
    // random back-to-back traffic, skips refuse the next offer
    repeat (300) begin
      rv = $random(seed);
      issue(op_t'(4'(rv[31:8] % 10)), rv[6:0], rv[7], rv[2:0],
            8'($random(seed)));
    end
    valid = 0;
    n = 0;
    while (q.size() > 0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (q.size() > 0) begin
      mismatches++;
    end
    summarize;
  end
endmodule
`default_nettype wire
